// file: fros_init.sv
// Reset handling and almost-empty/almost-full offset setup of a clocked FIFO.
`timescale 1ns/1ps
`default_nettype none


module fros_init (
	// System clock and reset
	input  wire logic                     mclk_i,
	input  wire logic                     rst_n_i,
	// Port clocks and reset pin
	input  wire logic                     write_port_clock_i,
	input  wire logic                     read_port_clock_i,
	input  wire logic                     fifo_reset_n_i,
	// Offset selects, doubling as serial data and enable
	input  wire logic                     offset_select_lo_i,
	input  wire logic                     offset_select_hi_i,
	// Write port
	input  wire logic                     fifo_write_i,
	input  wire logic [fros_pkg::OFS_W-1:0] write_data_i,
	// Flags
	output logic                          input_ready_o,
	output logic                          output_ready_o,
	output logic                          almost_empty_n_o,
	output logic                          almost_full_n_o,
	output logic                          mail_to_b_full_n_o,
	output logic                          mail_to_a_full_n_o,
	// Offsets, pointers and status
	output logic [fros_pkg::OFS_W-1:0]    almost_empty_offset_o,
	output logic [fros_pkg::OFS_W-1:0]    almost_full_offset_o,
	output logic [1:0]                    offset_mode_o,
	output logic [fros_pkg::PTR_W-1:0]    write_ptr_o,
	output logic [fros_pkg::PTR_W-1:0]    read_ptr_o,
	output logic                          store_word_o,
	output logic                          reset_long_enough_o
);

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	localparam int PW = 6 + fros_pkg::OFS_W;

	logic [PW-1:0] pins_s;
	logic                      wclk_s;
	logic                      rclk_s;
	logic                      rstp_s;
	logic                      sel_lo_s;
	logic                      sel_hi_s;
	logic                      wr_s;
	logic [fros_pkg::OFS_W-1:0] data_s;

	// The reset pin is asynchronous to everything and is only read after two flops.
	fros_sync #(.W(PW)) u_sync (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.d_i     ({write_port_clock_i, read_port_clock_i, fifo_reset_n_i,
			offset_select_lo_i, offset_select_hi_i, fifo_write_i, write_data_i}),
		.q_o     (pins_s)
	);

	assign {wclk_s, rclk_s, rstp_s, sel_lo_s, sel_hi_s, wr_s, data_s} = pins_s;

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		fros_pkg::fros_phase_t      phase;
		fros_pkg::fros_mode_t       mode;
		logic                       wclk_d;
		logic                       rclk_d;
		logic                       rstp_d;
		logic [2:0]                 wedges;
		logic [2:0]                 redges;
		logic [1:0]                 ir_cnt;
		logic [fros_pkg::CNT_W-1:0] ser_cnt;
		logic [1:0]                 loads;
		logic [fros_pkg::OFS_W-1:0] ofs_x;
		logic [fros_pkg::OFS_W-1:0] ofs_y;
		logic [fros_pkg::PTR_W-1:0] wptr;
		logic [fros_pkg::PTR_W-1:0] rptr;
		logic                       ir_stage;
		logic                       ir;
		logic                       store;
		logic                       ordy;
		logic                       ae_n;
		logic                       af_n;
		logic                       mb_b_n;
		logic                       mb_a_n;
	} fros_state_t;

	fros_state_t st;
	fros_state_t next_st;

	function automatic logic [2:0] sat_inc(input logic [2:0] v);
		sat_inc = (v >= fros_pkg::RST_EDGES_MIN) ? v : v + 3'h1;
	endfunction : sat_inc

	logic wclk_rise;
	logic rclk_rise;
	logic release_now;

	assign wclk_rise   = wclk_s & ~st.wclk_d;
	assign rclk_rise   = rclk_s & ~st.rclk_d;
	assign release_now = rstp_s & ~st.rstp_d;

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		next_st        = st;
		next_st.wclk_d = wclk_s;
		next_st.rclk_d = rclk_s;
		next_st.rstp_d = rstp_s;
		next_st.store  = 1'b0;
		if (!rstp_s) begin
			// Pointers and flags are held at their reset values.
			next_st.phase    = fros_pkg::PH_RESET;
			next_st.wptr     = fros_pkg::PTR_RESET;
			next_st.rptr     = fros_pkg::PTR_RESET;
			next_st.ir_stage = 1'b0;
			next_st.ir       = 1'b0;
			next_st.ir_cnt   = 2'h0;
			next_st.ser_cnt  = '0;
			next_st.loads    = 2'h0;
			next_st.ordy     = 1'b0;
			next_st.ae_n     = 1'b0;
			next_st.af_n     = 1'b1;
			next_st.mb_b_n   = 1'b1;
			next_st.mb_a_n   = 1'b1;
			if (st.rstp_d) begin
				next_st.wedges = 3'h0;
				next_st.redges = 3'h0;
			end else begin
				if (wclk_rise) begin
					next_st.wedges = sat_inc(st.wedges);
				end
				if (rclk_rise) begin
					next_st.redges = sat_inc(st.redges);
				end
			end
		end else if (release_now) begin
			// The selects are caught on the same cycle the released reset is seen.
			next_st.mode = fros_pkg::fros_mode_t'({sel_hi_s, sel_lo_s});
			case (fros_pkg::fros_mode_t'({sel_hi_s, sel_lo_s}))
				fros_pkg::MODE_PRESET8: begin
					next_st.ofs_x = fros_pkg::PRESET_LOW;
					next_st.ofs_y = fros_pkg::PRESET_LOW;
					next_st.phase = fros_pkg::PH_WAIT_IR;
				end
				fros_pkg::MODE_PRESET64: begin
					next_st.ofs_x = fros_pkg::PRESET_HIGH;
					next_st.ofs_y = fros_pkg::PRESET_HIGH;
					next_st.phase = fros_pkg::PH_WAIT_IR;
				end
				fros_pkg::MODE_SERIAL: begin
					next_st.phase = fros_pkg::PH_SERIAL;
				end
				default: begin
					next_st.phase = fros_pkg::PH_WAIT_IR;
				end
			endcase
		end else begin
			case (st.phase)
				fros_pkg::PH_WAIT_IR: begin
					// Input ready needs two write-clock edges, passing two stages.
					if (wclk_rise) begin
						next_st.ir_cnt = st.ir_cnt + 2'h1;
						if (st.ir_cnt == fros_pkg::IR_EDGES - 2'h1) begin
							next_st.ir    = 1'b1;
							next_st.phase = fros_pkg::PH_RUN;
						end else begin
							next_st.ir_stage = 1'b1;
						end
					end
				end
				fros_pkg::PH_SERIAL: begin
					if (wclk_rise && !sel_hi_s) begin
						{next_st.ofs_y, next_st.ofs_x} = {st.ofs_y[fros_pkg::OFS_W-2:0],
							st.ofs_x, sel_lo_s};
						next_st.ser_cnt = st.ser_cnt + 5'h01;
						if (st.ser_cnt == fros_pkg::SER_LAST) begin
							next_st.ir_stage = 1'b1;
							next_st.phase    = fros_pkg::PH_SER_DONE;
						end
					end
				end
				fros_pkg::PH_SER_DONE: begin
					if (wclk_rise) begin
						next_st.ir    = 1'b1;
						next_st.phase = fros_pkg::PH_RUN;
					end
				end
				fros_pkg::PH_RUN: begin
					if (wclk_rise && wr_s && st.ir) begin
						if (st.mode == fros_pkg::MODE_PARALLEL && st.loads == 2'h0) begin
							next_st.ofs_y = data_s;
							next_st.loads = 2'h1;
						end else if (st.mode == fros_pkg::MODE_PARALLEL
							&& st.loads == 2'h1) begin
							next_st.ofs_x = data_s;
							next_st.loads = 2'h2;
						end else begin
							next_st.store = 1'b1;
							next_st.wptr  = st.wptr + 11'h001;
						end
					end
				end
				default: begin
					next_st.phase = fros_pkg::PH_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			st <= '{phase: fros_pkg::PH_RESET, mode: fros_pkg::MODE_PARALLEL,
				wclk_d: 1'b0, rclk_d: 1'b0, rstp_d: 1'b0, wedges: 3'h0, redges: 3'h0,
				ir_cnt: 2'h0, ser_cnt: 5'h00, loads: 2'h0,
				ofs_x: fros_pkg::OFS_RESET, ofs_y: fros_pkg::OFS_RESET,
				wptr: fros_pkg::PTR_RESET, rptr: fros_pkg::PTR_RESET,
				ir_stage: 1'b0, ir: 1'b0, store: 1'b0, ordy: 1'b0, ae_n: 1'b0, af_n: 1'b1,
				mb_b_n: 1'b1, mb_a_n: 1'b1};
		end else begin
			st <= next_st;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	// Without a data path the FIFO stays empty, so the flags other than input ready keep their reset levels.
	assign input_ready_o         = st.ir;
	assign output_ready_o        = st.ordy;
	assign almost_empty_n_o      = st.ae_n;
	assign almost_full_n_o       = st.af_n;
	assign mail_to_b_full_n_o    = st.mb_b_n;
	assign mail_to_a_full_n_o    = st.mb_a_n;
	assign almost_empty_offset_o = st.ofs_x;
	assign almost_full_offset_o  = st.ofs_y;
	assign offset_mode_o         = st.mode;
	assign write_ptr_o           = st.wptr;
	assign read_ptr_o            = st.rptr;
	assign store_word_o          = st.store;
	assign reset_long_enough_o   = (st.wedges >= fros_pkg::RST_EDGES_MIN)
		&& (st.redges >= fros_pkg::RST_EDGES_MIN);

endmodule : fros_init

`default_nettype wire

// file: fros_pkg.sv
// Constants and types shared by the FIFO reset and offset setup block.
package fros_pkg;

	// ---------------------------------------------------------------
	// Widths
	// ---------------------------------------------------------------
	localparam int OFS_W   = 11;
	localparam int PTR_W   = 11;
	localparam int SER_LEN = 2 * OFS_W;
	localparam int CNT_W   = 5;

	// ---------------------------------------------------------------
	// Reset and timing counts
	// ---------------------------------------------------------------
	localparam logic [2:0]       RST_EDGES_MIN = 3'h4;
	localparam logic [1:0]       IR_EDGES      = 2'h2;
	localparam logic [CNT_W-1:0] SER_LAST      = 5'h15;

	// ---------------------------------------------------------------
	// Offset presets and reset values
	// ---------------------------------------------------------------
	localparam logic [OFS_W-1:0] PRESET_LOW  = 11'h008;
	localparam logic [OFS_W-1:0] PRESET_HIGH = 11'h040;
	localparam logic [OFS_W-1:0] OFS_RESET   = 11'h000;
	localparam logic [PTR_W-1:0] PTR_RESET   = 11'h000;

	// ---------------------------------------------------------------
	// Offset load modes, coded as {select_hi, select_lo}
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_PARALLEL = 2'b00,
		MODE_PRESET8  = 2'b01,
		MODE_PRESET64 = 2'b10,
		MODE_SERIAL   = 2'b11
	} fros_mode_t;

	// ---------------------------------------------------------------
	// Setup phases
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		PH_RESET    = 3'b000,
		PH_WAIT_IR  = 3'b001,
		PH_SERIAL   = 3'b010,
		PH_SER_DONE = 3'b011,
		PH_RUN      = 3'b100
	} fros_phase_t;

endpackage : fros_pkg

// file: fros_sync.sv
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
`default_nettype none

module fros_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         mclk_i,
	input  wire logic         rst_n_i,
	// Asynchronous input and synchronised output
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	logic [W-1:0] meta;

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			meta <= '0;
			q_o  <= '0;
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end

endmodule : fros_sync

`default_nettype wire

// file: fros_init_sva.sv
// Assertions on the reset and offset setup block.
`timescale 1ns/1ps
`default_nettype none
module fros_init_sva (
	input wire logic        mclk_i,
	input wire logic        rst_n_i,
	input wire logic        write_port_clock_i,
	input wire logic        fifo_reset_n_i,
	input wire logic        offset_select_lo_i,
	input wire logic        offset_select_hi_i,
	input wire logic        input_ready_o,
	input wire logic        output_ready_o,
	input wire logic        almost_empty_n_o,
	input wire logic        almost_full_n_o,
	input wire logic        mail_to_b_full_n_o,
	input wire logic        mail_to_a_full_n_o,
	input wire logic [10:0] almost_empty_offset_o,
	input wire logic [10:0] almost_full_offset_o,
	input wire logic [1:0]  offset_mode_o,
	input wire logic [10:0] write_ptr_o,
	input wire logic        store_word_o
);
	// Edges are counted after the same two-flop delay the block uses.
	logic [2:0] wc;
	logic [1:0] rp;
	logic [1:0] ne;
	logic       we;
	assign we = wc[1] & ~wc[2];
	always_ff @(posedge mclk_i) begin
		wc <= {wc[1:0], write_port_clock_i};
		rp <= {rp[0], fifo_reset_n_i};
		if (!rp[1]) begin
			ne <= 2'h0;
		end else if (we && ne != 2'h3) begin
			ne <= ne + 2'h1;
		end
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	sequence release_s; $rose(fifo_reset_n_i); endsequence
	sequence pin_low_s; !fifo_reset_n_i [*5]; endsequence
	rst_clear_a: assert property (pin_low_s |-> !input_ready_o && write_ptr_o == 11'h000)
		else $error("ready or pointer not cleared");
	fixed_flags_a: assert property (!output_ready_o && !almost_empty_n_o && almost_full_n_o)
		else $error("ready or almost flag wrong");
	mail_empty_a: assert property (mail_to_b_full_n_o && mail_to_a_full_n_o)
		else $error("mailbox flag low");
	ir_delay_a: assert property ($rose(input_ready_o) |-> ne >= 2'h2)
		else $error("input ready early");
	preset_edge_a: assert property ($rose(input_ready_o) && offset_mode_o inside {2'b01, 2'b10}
		|-> ne == 2'h2 && $past(we)) else $error("input ready not on second edge");
	mode_take_a: assert property (release_s
		|-> ##4 offset_mode_o == $past({offset_select_hi_i, offset_select_lo_i}, 4))
		else $error("mode wrong");
	preset_val_a: assert property (release_s and (offset_select_hi_i ^ offset_select_lo_i)
		|-> ##5 almost_full_offset_o == almost_empty_offset_o && almost_empty_offset_o ==
		($past(offset_select_lo_i, 5) ? 11'h008 : 11'h040)) else $error("preset offset wrong");
	ir_sync_a: assert property (release_s |-> !input_ready_o [*3])
		else $error("input ready not synchronised");
	store_gate_a: assert property (store_word_o |-> input_ready_o)
		else $error("store while not ready");
endmodule : fros_init_sva
`default_nettype wire

// file: fros_host.sv
// Host-side model driving the port clocks, reset pin, selects and write port.
`timescale 1ns/1ps
`default_nettype none
module fros_host (
	input  wire logic   mclk_i,
	output logic        wclk_o,
	output logic        rclk_o,
	output logic        rst_pin_n_o,
	output logic        sel_lo_o,
	output logic        sel_hi_o,
	output logic        wr_o,
	output logic [10:0] data_o
);
	// Free port clocks at an eighth of the system rate, a quarter period apart.
	logic [2:0] ph = 3'h0;
	initial {wclk_o, rclk_o, rst_pin_n_o, sel_lo_o, sel_hi_o, wr_o, data_o} = '0;
	always @(posedge mclk_i) begin
		ph <= ph + 3'h1;
		wclk_o <= ph[2];
		rclk_o <= ph[2] ^ ph[1];
	end
	task automatic sync();
		@(negedge wclk_o);
		@(posedge mclk_i);
	endtask : sync
	task automatic pin_reset(input logic [1:0] mode);
		sync();
		rst_pin_n_o <= 1'b0;
		{sel_hi_o, sel_lo_o} <= mode;
		repeat (5) @(posedge rclk_o);
		sync();
		rst_pin_n_o <= 1'b1;
	endtask : pin_reset
	task automatic write_word(input logic [10:0] d);
		sync();
		wr_o <= 1'b1;
		data_o <= d;
		sync();
		wr_o <= 1'b0;
		data_o <= ~d;
	endtask : write_word
	task automatic shift_bits(input logic [21:0] v);
		for (int i = 21; i >= 0; i--) begin
			sync();
			sel_hi_o <= 1'b0;
			sel_lo_o <= v[i];
		end
		sync();
		sel_hi_o <= 1'b1;
		sel_lo_o <= ~v[0];
	endtask : shift_bits
endmodule : fros_host
`default_nettype wire

// file: fros_init_tb.sv
// Self-checking testbench for the reset and offset setup block.
`timescale 1ns/1ps
`default_nettype none
module fros_init_tb;
	typedef struct {logic [1:0] m; logic [10:0] x; logic [10:0] y;} fros_row_t;
	logic        mclk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        wclk, rclk, rpin_n, sel_lo, sel_hi, wr;
	logic        ir, ordy, ae_n, af_n, mb_n, ma_n, store, long_rst;
	logic [10:0] wdata, x_ofs, y_ofs, wptr, rptr;
	logic [1:0]  mode;
	int          mismatches = 0;
	int          checks_done = 0;
	int          stores = 0;
	fros_row_t   rows [4] = '{'{2'b01, 11'h008, 11'h008}, '{2'b10, 11'h040, 11'h040},
		'{2'b00, 11'h123, 11'h7fc}, '{2'b11, 11'h001, 11'h5a5}};
	always #12.5 mclk_i = ~mclk_i;
	always @(posedge mclk_i) if (store === 1'b1) stores++;
	fros_host fros_host_i (.mclk_i(mclk_i), .wclk_o(wclk), .rclk_o(rclk), .rst_pin_n_o(rpin_n),
		.sel_lo_o(sel_lo), .sel_hi_o(sel_hi), .wr_o(wr), .data_o(wdata));
	fros_init fros_init_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .write_port_clock_i(wclk),
		.read_port_clock_i(rclk), .fifo_reset_n_i(rpin_n), .offset_select_lo_i(sel_lo),
		.offset_select_hi_i(sel_hi), .fifo_write_i(wr), .write_data_i(wdata), .input_ready_o(ir),
		.output_ready_o(ordy), .almost_empty_n_o(ae_n), .almost_full_n_o(af_n),
		.mail_to_b_full_n_o(mb_n), .mail_to_a_full_n_o(ma_n), .almost_empty_offset_o(x_ofs),
		.almost_full_offset_o(y_ofs), .offset_mode_o(mode), .write_ptr_o(wptr),
		.read_ptr_o(rptr), .store_word_o(store), .reset_long_enough_o(long_rst));
	task automatic check(input string name, input logic [10:0] seen, input logic [10:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic wait_ir();
		int n = 0;
		while (ir !== 1'b1 && n < 300) begin
			@(posedge mclk_i);
			n++;
		end
		check("input_ready", ir, 11'h001);
	endtask : wait_ir
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : summarize
	initial begin
		repeat (20000) @(posedge mclk_i);
		mismatches++;
		summarize();
	end
	initial begin
		repeat (3) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		foreach (rows[i]) begin
			fros_host_i.pin_reset(rows[i].m);
			check("ready_early", ir, 11'h000);
			check("long_reset", long_rst, 11'h001);
			if (rows[i].m == 2'b11) fros_host_i.shift_bits({rows[i].y, rows[i].x});
			wait_ir();
			if (rows[i].m == 2'b00) begin
				fros_host_i.write_word(rows[i].y);
				fros_host_i.write_word(rows[i].x);
			end
			check("mode", mode, rows[i].m);
			check("ae_offset", x_ofs, rows[i].x);
			check("af_offset", y_ofs, rows[i].y);
			check("wptr", wptr, 11'h000);
			$display("row %0d done", i);
		end
		// Extreme offsets, then a third write that must be stored and move the write pointer.
		fros_host_i.pin_reset(2'b00);
		wait_ir();
		fros_host_i.write_word(11'h7ff);
		fros_host_i.write_word(11'h000);
		fros_host_i.write_word(11'h055);
		repeat (4) @(posedge mclk_i);
		check("af_edge", y_ofs, 11'h7ff);
		check("stores", stores, 11'h001);
		check("wptr_one", wptr, 11'h001);
		$display("parallel store done");
		fork
			fros_host_i.pin_reset(2'b10);
			begin
				repeat (30) @(posedge mclk_i);
				check("ir_reset", ir, 11'h000);
				check("ptr_reset", {wptr | rptr}, 11'h000);
				check("flags", {ordy, ae_n, af_n, mb_n, ma_n}, 11'h007);
				check("short_reset", long_rst, 11'h000);
			end
		join
		wait_ir();
		check("preset64", x_ofs, 11'h040);
		$display("mid-run reset done");
		// A write before serial setup ends is refused.
		fros_host_i.pin_reset(2'b11);
		fros_host_i.write_word(11'h3ff);
		fros_host_i.shift_bits({11'h400, 11'h7ff});
		wait_ir();
		check("ser_af", y_ofs, 11'h400);
		check("ser_ae", x_ofs, 11'h7ff);
		check("refused", stores, 11'h001);
		$display("serial refusal done");
		summarize();
	end
endmodule : fros_init_tb
bind fros_init fros_init_sva fros_init_sva_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
	.write_port_clock_i(write_port_clock_i), .fifo_reset_n_i(fifo_reset_n_i),
	.offset_select_lo_i(offset_select_lo_i), .offset_select_hi_i(offset_select_hi_i),
	.input_ready_o(input_ready_o), .output_ready_o(output_ready_o),
	.almost_empty_n_o(almost_empty_n_o), .almost_full_n_o(almost_full_n_o),
	.mail_to_b_full_n_o(mail_to_b_full_n_o), .mail_to_a_full_n_o(mail_to_a_full_n_o),
	.almost_empty_offset_o(almost_empty_offset_o), .almost_full_offset_o(almost_full_offset_o),
	.offset_mode_o(offset_mode_o), .write_ptr_o(write_ptr_o), .store_word_o(store_word_o));
`default_nettype wire
